// ==== hdl/rsr_pkg.sv ====
// Constants for the special register bank and the paged nonvolatile store.
// Assumes a 50 MHz core clock and a byte-level access port fed by a serial slave engine.
package rsr_pkg;
  localparam logic [7:0] OFS_WDOG_LO = 8'h08;
  localparam logic [7:0] OFS_WDOG_HI = 8'h09;
  localparam logic [7:0] OFS_CHARGE = 8'h0A;
  localparam logic [7:0] OFS_FLAGS = 8'h0B;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_LAST_REG = 8'h0C;
  localparam int BIT_OSC_HALT = 7;
  localparam int BIT_WDOG_EXP = 6;
  localparam int BIT_OSC_OFF_BAT = 7;
  localparam int BIT_WDOG_ON = 1;
  localparam int BIT_WDOG_RST = 0;
  localparam logic [3:0] CHARGE_KEY = 4'hA;
  localparam logic [7:0] CHARGE_RESET = 8'h00;
  localparam logic [1:0] DIODE_NONE = 2'h1;
  localparam logic [1:0] DIODE_ONE = 2'h2;
  localparam logic [1:0] RES_250 = 2'h1;
  localparam logic [1:0] RES_2K = 2'h2;
  localparam logic [1:0] RES_4K = 2'h3;
  localparam logic [1:0] BLK_REGS = 2'h0;
  localparam logic [1:0] BLK_NV0 = 2'h1;
  localparam logic [1:0] BLK_NV1 = 2'h2;
  localparam int NV_BYTES = 512;
  localparam int PAGE_BYTES = 8;
  localparam int CLK_HZ = 50_000_000;
  localparam longint TICK_PERIOD_US = 10_000;
  localparam int TICK_CYCLES = int'((longint'(CLK_HZ) * TICK_PERIOD_US) / 1_000_000);
  localparam int RST_PULSE_CYCLES = 8192;
  localparam int NV_PROG_CYCLES = 64;
endpackage

// ==== hdl/rsr_tick_div.sv ====
// Divider giving a one-cycle enable pulse every PERIOD clocks.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module rsr_tick_div #(
  parameter int PERIOD = 500_000
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  output logic tick
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (cnt_ff == LAST);
      cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
    end
  end
endmodule

// ==== hdl/rsr_special_regs.sv ====
// Special registers, watchdog counter and paged nonvolatile store of the clock chip.
// Assumes a serial slave engine on the same clock hands over address, byte and STOP pulses.
`timescale 1ns/100ps
module rsr_special_regs
  import rsr_pkg::*;
#(
  parameter int TICK_CYC = rsr_pkg::TICK_CYCLES,
  parameter int RST_CYC = rsr_pkg::RST_PULSE_CYCLES,
  parameter int PROG_CYC = rsr_pkg::NV_PROG_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic acc_addr_valid,
  input wire logic [1:0] acc_block,
  input wire logic [7:0] acc_word,
  input wire logic acc_wr_valid,
  input wire logic [7:0] acc_wr_data,
  input wire logic acc_rd_req,
  input wire logic acc_stop,
  output logic [7:0] acc_rd_data,
  output logic acc_rd_valid,
  output logic acc_busy,
  input wire logic osc_running,
  input wire logic on_backup_supply,
  output logic osc_enable,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic charge_enable,
  output logic charge_diode,
  output logic [1:0] charge_res_sel
);
  import rsr_pkg::*;

  typedef enum logic [1:0] {NV_IDLE, NV_COMMIT, NV_PROG} rsr_nv_state_t;

  logic osc_meta_ff, osc_sync_ff, osc_prev_ff;
  logic bat_meta_ff, bat_sync_ff;
  logic osc_halt_flag_ff, wdog_expired_flag_ff;
  logic osc_off_on_battery_ff, wdog_counter_on_ff, wdog_drives_reset_pin_ff;
  logic [7:0] charge_reg_ff;
  logic [15:0] wdog_cnt_ff, wdog_seed_ff;
  logic [7:0] ptr_ff;
  logic [1:0] blk_ff;
  logic [7:0] nv_mem [NV_BYTES];
  logic [7:0] page_buf_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_vld_ff;
  logic [8:0] page_base_ff;
  logic [2:0] commit_idx_ff;
  rsr_nv_state_t nv_state_ff;
  logic [$clog2(PROG_CYC+1)-1:0] prog_cnt_ff;
  logic [$clog2(RST_CYC+1)-1:0] rst_cnt_ff;
  logic osc_enable_prev_ff;
  logic tick;
  logic wdog_expire;
  logic wr_reg, rd_reg, wr_nv, rd_nv;
  logic flag_write;
  logic [8:0] nv_addr;
  logic [7:0] reg_rdata;

  // Packed BCD countdown of four digits, used on each tick while the watchdog counter is on and not zero, unless that cycle reloads it
  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int d = 0; d < 4; d++)
    begin
      if (borrow)
      begin
        if (r[d*4 +: 4] == 4'h0)
          r[d*4 +: 4] = 4'h9;
        else
        begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  rsr_tick_div #(
    .PERIOD(TICK_CYC)
  ) u_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // Pin-side levels pass two flops before anything looks at them
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
      bat_meta_ff <= 1'b0;
      bat_sync_ff <= 1'b0;
    end
    else
    begin
      osc_meta_ff <= osc_running;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
      bat_meta_ff <= on_backup_supply;
      bat_sync_ff <= bat_meta_ff;
    end
  end

  // Access is refused during the reset pulse and the nonvolatile write cycle
  assign wr_reg = acc_wr_valid && !acc_busy && blk_ff == BLK_REGS;
  assign rd_reg = acc_rd_req && !acc_busy && blk_ff == BLK_REGS;
  assign wr_nv = acc_wr_valid && !acc_busy && (blk_ff == BLK_NV0 || blk_ff == BLK_NV1);
  assign rd_nv = acc_rd_req && !acc_busy && (blk_ff == BLK_NV0 || blk_ff == BLK_NV1);
  assign nv_addr = {blk_ff == BLK_NV1, ptr_ff};
  assign flag_write = wr_reg && ptr_ff == OFS_FLAGS;

  // Address pointer; register block wraps after its last register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ptr_ff <= 8'h00;
      blk_ff <= BLK_REGS;
    end
    else if (acc_addr_valid && !acc_busy)
    begin
      ptr_ff <= acc_word;
      blk_ff <= acc_block;
    end
    else if (wr_reg || rd_reg)
      ptr_ff <= (ptr_ff >= OFS_LAST_REG) ? 8'h00 : ptr_ff + 8'h01;
    else if (rd_nv)
      ptr_ff <= ptr_ff + 8'h01;
    else if (wr_nv)
      ptr_ff <= {ptr_ff[7:3], ptr_ff[2:0] + 3'h1};
  end

  // Oscillator gate on backup power
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      osc_enable <= 1'b1;
      osc_enable_prev_ff <= 1'b1;
    end
    else
    begin
      osc_enable <= !(osc_off_on_battery_ff && bat_sync_ff);
      osc_enable_prev_ff <= osc_enable;
    end
  end

  // Sticky flags: the set term is applied after the clear so an event is never lost
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      osc_halt_flag_ff <= 1'b1;
      wdog_expired_flag_ff <= 1'b0;
    end
    else
    begin
      if (flag_write && !acc_wr_data[BIT_OSC_HALT])
        osc_halt_flag_ff <= 1'b0;
      if (flag_write && !acc_wr_data[BIT_WDOG_EXP])
        wdog_expired_flag_ff <= 1'b0;
      if ((osc_prev_ff && !osc_sync_ff) || (osc_enable_prev_ff && !osc_enable))
        osc_halt_flag_ff <= 1'b1;
      if (wdog_expire)
        wdog_expired_flag_ff <= 1'b1;
    end
  end

  // Control bits; unlisted bits have no storage
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      osc_off_on_battery_ff <= 1'b0;
      wdog_counter_on_ff <= 1'b0;
      wdog_drives_reset_pin_ff <= 1'b0;
    end
    else if (wr_reg && ptr_ff == OFS_CONTROL)
    begin
      osc_off_on_battery_ff <= acc_wr_data[BIT_OSC_OFF_BAT];
      wdog_counter_on_ff <= acc_wr_data[BIT_WDOG_ON];
      wdog_drives_reset_pin_ff <= acc_wr_data[BIT_WDOG_RST];
    end
  end

  // Charger select register and decoded charger drive
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      charge_reg_ff <= CHARGE_RESET;
    else if (wr_reg && ptr_ff == OFS_CHARGE)
      charge_reg_ff <= acc_wr_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      charge_enable <= 1'b0;
      charge_diode <= 1'b0;
      charge_res_sel <= 2'h0;
    end
    else
    begin
      charge_enable <= charge_reg_ff[7:4] == CHARGE_KEY
        && (charge_reg_ff[3:2] == DIODE_NONE || charge_reg_ff[3:2] == DIODE_ONE)
        && charge_reg_ff[1:0] != 2'h0;
      charge_diode <= charge_reg_ff[3:2] == DIODE_ONE;
      charge_res_sel <= charge_reg_ff[1:0];
    end
  end

  // Watchdog: only an access that reloads the counter may cancel expiry, else it is lost
  assign wdog_expire = tick && wdog_counter_on_ff && wdog_cnt_ff == 16'h0001
    && !((wr_reg || rd_reg) && (ptr_ff == OFS_WDOG_LO || ptr_ff == OFS_WDOG_HI));

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wdog_cnt_ff <= 16'h0000;
      wdog_seed_ff <= 16'h0000;
    end
    else if (wr_reg && ptr_ff == OFS_WDOG_LO)
    begin
      wdog_cnt_ff <= {wdog_seed_ff[15:8], acc_wr_data};
      wdog_seed_ff <= {wdog_seed_ff[15:8], acc_wr_data};
    end
    else if (wr_reg && ptr_ff == OFS_WDOG_HI)
    begin
      wdog_cnt_ff <= {acc_wr_data, wdog_seed_ff[7:0]};
      wdog_seed_ff <= {acc_wr_data, wdog_seed_ff[7:0]};
    end
    else if (rd_reg && (ptr_ff == OFS_WDOG_LO || ptr_ff == OFS_WDOG_HI) && wdog_counter_on_ff)
      wdog_cnt_ff <= wdog_seed_ff;
    else if (tick && wdog_counter_on_ff && wdog_cnt_ff != 16'h0000)
      wdog_cnt_ff <= bcd_dec(wdog_cnt_ff);
  end

  // Open-drain reset pin; output level is always low, the enable makes the pulse
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      rst_cnt_ff <= '0;
      reset_pin_oe <= 1'b0;
      reset_pin_o <= 1'b0;
    end
    else
    begin
      reset_pin_o <= 1'b0;
      if (wdog_expire && wdog_drives_reset_pin_ff)
      begin
        rst_cnt_ff <= ($bits(rst_cnt_ff))'(RST_CYC);
        reset_pin_oe <= 1'b1;
      end
      else if (rst_cnt_ff != '0)
      begin
        rst_cnt_ff <= rst_cnt_ff - 1'b1;
        reset_pin_oe <= rst_cnt_ff != ($bits(rst_cnt_ff))'(1);
      end
    end
  end

  // Page buffer: base taken from the first data byte, slot from low pointer bits
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      page_vld_ff <= '0;
      page_base_ff <= 9'h000;
      for (int i = 0; i < PAGE_BYTES; i++)
        page_buf_ff[i] <= 8'h00;
    end
    else if (nv_state_ff == NV_PROG && prog_cnt_ff == '0)
      page_vld_ff <= '0;
    else if (wr_nv)
    begin
      if (page_vld_ff == '0)
        page_base_ff <= {nv_addr[8:3], 3'h0};
      page_buf_ff[ptr_ff[2:0]] <= acc_wr_data;
      page_vld_ff[ptr_ff[2:0]] <= 1'b1;
    end
  end

  // Commit after STOP: unwritten bytes of the page keep their contents
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      nv_state_ff <= NV_IDLE;
      commit_idx_ff <= 3'h0;
      prog_cnt_ff <= '0;
    end
    else
    begin
      unique case (nv_state_ff)
        NV_IDLE:
        begin
          commit_idx_ff <= 3'h0;
          if (acc_stop && page_vld_ff != '0)
            nv_state_ff <= NV_COMMIT;
        end
        NV_COMMIT:
        begin
          commit_idx_ff <= commit_idx_ff + 3'h1;
          if (commit_idx_ff == 3'(PAGE_BYTES - 1))
          begin
            nv_state_ff <= NV_PROG;
            prog_cnt_ff <= ($bits(prog_cnt_ff))'(PROG_CYC);
          end
        end
        NV_PROG:
        begin
          if (prog_cnt_ff == '0)
            nv_state_ff <= NV_IDLE;
          else
            prog_cnt_ff <= prog_cnt_ff - 1'b1;
        end
      endcase
    end
  end

  // Array has no reset so it maps onto memory
  always_ff @(posedge core_clk)
  begin
    if (nv_state_ff == NV_COMMIT && page_vld_ff[commit_idx_ff])
      nv_mem[{page_base_ff[8:3], commit_idx_ff}] <= page_buf_ff[commit_idx_ff];
  end

  always_comb
  begin
    reg_rdata = 8'h00;
    unique case (ptr_ff)
      OFS_WDOG_LO: reg_rdata = wdog_cnt_ff[7:0];
      OFS_WDOG_HI: reg_rdata = wdog_cnt_ff[15:8];
      OFS_CHARGE: reg_rdata = charge_reg_ff;
      OFS_FLAGS: reg_rdata = {osc_halt_flag_ff, wdog_expired_flag_ff, 6'h00};
      OFS_CONTROL: reg_rdata = {osc_off_on_battery_ff, 5'h00, wdog_counter_on_ff,
        wdog_drives_reset_pin_ff};
      default: reg_rdata = 8'h00;
    endcase
  end

  // Read answer one cycle after the request; unmapped block reads zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      acc_rd_data <= 8'h00;
      acc_rd_valid <= 1'b0;
      acc_busy <= 1'b0;
    end
    else
    begin
      acc_rd_valid <= acc_rd_req && !acc_busy;
      if (rd_reg)
        acc_rd_data <= reg_rdata;
      else if (rd_nv)
        acc_rd_data <= nv_mem[nv_addr];
      else if (acc_rd_req && !acc_busy)
        acc_rd_data <= 8'h00;
      acc_busy <= (nv_state_ff != NV_IDLE && !(nv_state_ff == NV_PROG && prog_cnt_ff == '0))
        || (acc_stop && page_vld_ff != '0 && nv_state_ff == NV_IDLE)
        || (wdog_expire && wdog_drives_reset_pin_ff)
        || (rst_cnt_ff > ($bits(rst_cnt_ff))'(1));
    end
  end
endmodule

// ==== verif/rsr_checker.sv ====
// Port-level assertions for the special register bank.
// Assumes binding onto rsr_special_regs, one clock, sync active-high reset.
`timescale 1ns/100ps
module rsr_checker #(
  parameter int RST_CYC = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic acc_addr_valid,
  input wire logic acc_wr_valid,
  input wire logic acc_rd_req,
  input wire logic on_backup_supply,
  input wire logic acc_rd_valid,
  input wire logic acc_busy,
  input wire logic osc_enable,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe,
  input wire logic charge_enable,
  input wire logic [1:0] charge_res_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  int oe_cnt_ff;
  // Length of the current reset pulse so far
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !reset_pin_oe)
      oe_cnt_ff <= 0;
    else
      oe_cnt_ff <= oe_cnt_ff + 1;
  end
  chk_osc_main_run: assert property (!on_backup_supply [*5] |-> osc_enable)
    else $error("oscillator stopped on main power");
  chk_charge_res_off: assert property (charge_enable |-> charge_res_sel != 2'h0)
    else $error("charger on with no resistor");
  chk_rst_pulse_len: assert property ($fell(reset_pin_oe) |-> oe_cnt_ff == RST_CYC)
    else $error("reset pulse length wrong");
  chk_rst_drive_low: assert property (reset_pin_oe |-> !reset_pin_o)
    else $error("reset pin driven high");
  chk_rst_blocks_bus: assert property (reset_pin_oe |-> acc_busy)
    else $error("access open during reset pulse");
  chk_busy_no_read: assert property (acc_busy && acc_rd_req |=> !acc_rd_valid)
    else $error("read answered while busy");
  chk_read_answer: assert property (acc_rd_req && !acc_addr_valid && !acc_busy
    |=> acc_rd_valid)
    else $error("read not answered");
  chk_charge_hold: assert property (!acc_wr_valid [*4] |-> $stable(charge_enable))
    else $error("charger changed without write");
endmodule
bind rsr_special_regs rsr_checker #(.RST_CYC(RST_CYC)) rsr_checker_i (.core_clk(core_clk),
  .sys_rst(sys_rst), .acc_addr_valid(acc_addr_valid), .acc_wr_valid(acc_wr_valid),
  .acc_rd_req(acc_rd_req), .on_backup_supply(on_backup_supply), .acc_rd_valid(acc_rd_valid),
  .acc_busy(acc_busy), .osc_enable(osc_enable), .reset_pin_o(reset_pin_o),
  .reset_pin_oe(reset_pin_oe), .charge_enable(charge_enable), .charge_res_sel(charge_res_sel));

// ==== verif/rsr_host_model.sv ====
// Host side of the byte access port: pointer, write, read and STOP strobes.
// Assumes the bench calls its tasks; strobes change just after a rising edge.
`timescale 1ns/100ps
module rsr_host_model (
  input wire logic core_clk,
  input wire logic acc_busy,
  input wire logic acc_rd_valid,
  input wire logic [7:0] acc_rd_data,
  output logic acc_addr_valid,
  output logic [1:0] acc_block,
  output logic [7:0] acc_word,
  output logic acc_wr_valid,
  output logic [7:0] acc_wr_data,
  output logic acc_rd_req,
  output logic acc_stop
);
  initial
  begin
    {acc_addr_valid, acc_wr_valid, acc_rd_req, acc_stop} = 4'h0;
    acc_block = 2'h0;
    acc_word = 8'h00;
    acc_wr_data = 8'h00;
  end
  task automatic strobe(input logic [3:0] m);
    @(posedge core_clk);
    #1;
    {acc_addr_valid, acc_wr_valid, acc_rd_req, acc_stop} = m;
    @(posedge core_clk);
    #1;
    {acc_addr_valid, acc_wr_valid, acc_rd_req, acc_stop} = 4'h0;
  endtask
  task automatic seek(input logic [1:0] blk, input logic [7:0] w);
    acc_block = blk;
    acc_word = w;
    strobe(4'h8);
  endtask
  task automatic wr(input logic [7:0] d);
    acc_wr_data = d;
    strobe(4'h4);
  endtask
  task automatic rd(output logic v, output logic [7:0] d);
    strobe(4'h2);
    v = acc_rd_valid;
    d = acc_rd_data;
  endtask
  // Nonvolatile bytes land only once STOP is seen
  task automatic stop();
    strobe(4'h1);
  endtask
  // Stands in for the bus retrying while the device refuses
  task automatic idle();
    for (int i = 0; i < 300 && acc_busy; i++)
      @(posedge core_clk);
    #1;
  endtask
endmodule

// ==== verif/rsr_special_regs_tb.sv ====
// Self-checking bench for the special register bank.
// Assumes shortened tick, pulse and program counts given by parameters below.
`timescale 1ns/100ps
module rsr_special_regs_tb;
  import rsr_pkg::*;
  localparam int TC = 20;
  logic core_clk = 0, sys_rst = 1, osc_ok = 1, on_backup_supply = 0, v;
  logic acc_addr_valid, acc_wr_valid, acc_rd_req, acc_stop, acc_rd_valid, acc_busy;
  logic osc_running, osc_enable, reset_pin_o, reset_pin_oe, charge_enable, charge_diode;
  logic [1:0] acc_block, charge_res_sel;
  logic [7:0] acc_word, acc_wr_data, acc_rd_data, b, c;
  logic [7:0] pg [8];
  logic [7:0] corner [9] = '{8'hA5, 8'hAA, 8'hAB, 8'hA9, 8'hA7, 8'hAD, 8'hAC, 8'h5B, 8'hA1};
  logic [15:0] lf = 16'hB327;
  int err_total = 0, cmp_count = 0, cyc = 0, n;
  assign osc_running = osc_enable & osc_ok;
  initial forever #10 core_clk = ~core_clk;
  rsr_special_regs #(.TICK_CYC(TC), .RST_CYC(16), .PROG_CYC(8)) rsr_special_regs_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .acc_addr_valid(acc_addr_valid),
    .acc_block(acc_block), .acc_word(acc_word), .acc_wr_valid(acc_wr_valid),
    .acc_wr_data(acc_wr_data), .acc_rd_req(acc_rd_req), .acc_stop(acc_stop),
    .acc_rd_data(acc_rd_data), .acc_rd_valid(acc_rd_valid), .acc_busy(acc_busy),
    .osc_running(osc_running), .on_backup_supply(on_backup_supply), .osc_enable(osc_enable),
    .reset_pin_o(reset_pin_o), .reset_pin_oe(reset_pin_oe), .charge_enable(charge_enable),
    .charge_diode(charge_diode), .charge_res_sel(charge_res_sel));
  rsr_host_model rsr_host_model_i (.core_clk(core_clk), .acc_busy(acc_busy),
    .acc_rd_valid(acc_rd_valid), .acc_rd_data(acc_rd_data), .acc_addr_valid(acc_addr_valid),
    .acc_block(acc_block), .acc_word(acc_word), .acc_wr_valid(acc_wr_valid),
    .acc_wr_data(acc_wr_data), .acc_rd_req(acc_rd_req), .acc_stop(acc_stop));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic chg_on(input logic [7:0] r);
    return r[7:4] == CHARGE_KEY && (r[3:2] == DIODE_NONE || r[3:2] == DIODE_ONE) && r[1:0] != 2'h0;
  endfunction
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] w, input logic [7:0] d);
    rsr_host_model_i.seek(BLK_REGS, w);
    rsr_host_model_i.wr(d);
  endtask
  task automatic rreg(input logic [7:0] w, input logic [7:0] e);
    rsr_host_model_i.seek(BLK_REGS, w);
    rsr_host_model_i.rd(v, b);
    chk1(v, 1'b1);
    chk8(b, e);
  endtask
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    tick(4);
    sys_rst = 0;
    rreg(OFS_CHARGE, CHARGE_RESET);
    rreg(OFS_FLAGS, 8'h80);
    rreg(OFS_CONTROL, 8'h00);
    wreg(OFS_FLAGS, 8'hFF);
    rreg(OFS_FLAGS, 8'h80);
    wreg(OFS_FLAGS, 8'h00);
    rreg(OFS_FLAGS, 8'h00);
    wreg(OFS_CONTROL, 8'h7C);
    rreg(OFS_CONTROL, 8'h00);
    for (n = 0; n < 16; n++)
    begin
      c = n < 9 ? corner[n] : lf[7:0];
      lf = lfsr(lf);
      if (n >= 12 && c[1:0] == RES_250) // Last passes: main supply above the limit
        c[1:0] = RES_2K;
      wreg(OFS_CHARGE, c);
      tick(2);
      chk1(charge_enable, chg_on(c));
      chk1(charge_diode, c[3:2] == DIODE_ONE);
      chk8({6'h00, charge_res_sel}, {6'h00, c[1:0]});
      rreg(OFS_CHARGE, c);
    end
    wreg(OFS_CONTROL, 8'h00);
    wreg(OFS_WDOG_LO, 8'h02);
    wreg(OFS_WDOG_HI, 8'h00);
    tick(100);
    rreg(OFS_WDOG_LO, 8'h02);
    wreg(OFS_CONTROL, 8'h03);
    for (n = 0; n < 200 && !reset_pin_oe; n++)
      tick(1);
    chk1(n >= TC && n <= 2 * TC + 4, 1'b1);
    chk1(reset_pin_o, 1'b0);
    chk1(acc_busy, 1'b1);
    rsr_host_model_i.idle();
    rreg(OFS_FLAGS, 8'h40);
    wreg(OFS_CONTROL, 8'h00);
    wreg(OFS_FLAGS, 8'h00);
    wreg(OFS_WDOG_LO, 8'h02);
    wreg(OFS_CONTROL, 8'h02);
    n = 0;
    repeat (150)
    begin
      tick(1);
      n += reset_pin_oe;
    end
    chk8(n[7:0], 8'h00);
    rreg(OFS_FLAGS, 8'h40);
    wreg(OFS_CONTROL, 8'h00);
    wreg(OFS_FLAGS, 8'h00);
    osc_ok = 0;
    tick(6);
    rreg(OFS_FLAGS, 8'h80);
    osc_ok = 1;
    wreg(OFS_FLAGS, 8'h00);
    on_backup_supply = 1;
    tick(6);
    chk1(osc_enable, 1'b1);
    wreg(OFS_CONTROL, 8'h80);
    tick(6);
    chk1(osc_enable, 1'b0);
    rreg(OFS_FLAGS, 8'h80);
    on_backup_supply = 0;
    tick(6);
    chk1(osc_enable, 1'b1);
    rsr_host_model_i.seek(BLK_NV0, 8'h08);
    rsr_host_model_i.wr(8'h5A);
    rsr_host_model_i.stop();
    rsr_host_model_i.idle();
    rsr_host_model_i.seek(BLK_NV0, 8'h05);
    for (n = 0; n < 10; n++)
    begin
      c = lf[7:0];
      lf = lfsr(lf);
      pg[(5 + n) % 8] = c;
      rsr_host_model_i.wr(c);
    end
    rsr_host_model_i.stop();
    rsr_host_model_i.rd(v, b);
    chk1(v, 1'b0);
    rsr_host_model_i.idle();
    rsr_host_model_i.seek(BLK_NV0, 8'h00);
    for (n = 0; n < 9; n++)
    begin
      rsr_host_model_i.rd(v, b);
      chk8(b, n < 8 ? pg[n] : 8'h5A);
    end
    rsr_host_model_i.seek(BLK_NV1, 8'hFF);
    rsr_host_model_i.wr(8'hC3);
    rsr_host_model_i.stop();
    rsr_host_model_i.idle();
    rsr_host_model_i.seek(BLK_NV1, 8'hFF);
    rsr_host_model_i.rd(v, b);
    chk8(b, 8'hC3);
    rsr_host_model_i.seek(2'h3, 8'h00);
    rsr_host_model_i.rd(v, b);
    chk8(b, 8'h00);
    print_verdict();
  end
endmodule
